// ### core/pbsp_ctl_end.sv
// memory controller end: turns user requests into pin cycles
`timescale 1ns/1ps
`default_nettype none
module pbsp_ctl_end #(
   parameter int   DATA_W      = pbsp_pkg::DATA_W,
   parameter int   LANES       = pbsp_pkg::LANES,
   parameter int   ADDR_W      = pbsp_pkg::ADDR_W,
   parameter logic BURST_ORDER = pbsp_pkg::ORDER_LIN
) (
   input  wire logic              clk,
   input  wire logic              rst_b,
   pbsp_if.ctl                    bus,
   input  wire logic              usr_req_valid,
   input  wire logic              usr_req_burst,
   input  wire logic              usr_req_write,
   input  wire logic [ADDR_W-1:0] usr_req_addr,
   input  wire logic [LANES-1:0]  usr_req_lanes,
   input  wire logic [DATA_W-1:0] usr_req_wdata,
   input  wire logic              usr_hold,
   input  wire logic              usr_sleep,
   output var  logic              usr_rsp_valid,
   output var  logic [DATA_W-1:0] usr_rsp_rdata
);
   import pbsp_pkg::*;

   logic              take;
   logic              is_load;
   logic              act_r;
   logic              wr_r;
   logic              dev_run;
   logic              cmd_v_r;
   logic              cmd_wr_r;
   logic [DATA_W-1:0] cmd_data_r;
   logic              p1_v_r;
   logic              p1_wr_r;
   logic [DATA_W-1:0] p1_data_r;
   logic              p2_v_r;
   logic              p2_wr_r;
   logic [DATA_W-1:0] p2_data_r;
   logic              p3_rd_r;

   assign take    = ~usr_hold & ~usr_sleep;
   assign is_load = usr_req_valid & ~usr_req_burst;
   // pins now on the wire are sampled by the sram at this edge
   assign dev_run = ~bus.clock_enable_n & ~bus.sleep_request;

   ////////////////////////////////////////////////////////////////////////
   // pin drivers
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bus.clock_enable_n         <= 1'b1;
         bus.sleep_request          <= 1'b0;
         bus.advance_or_load        <= 1'b0;
         bus.read_not_write         <= 1'b1;
         bus.select_low_a_n         <= 1'b1;
         bus.select_high_or_low_b_n <= 1'b1;
         bus.select_high            <= 1'b0;
         bus.lane_write_enable_n    <= '1;
         bus.word_address           <= '0;
         bus.burst_order_select     <= BURST_ORDER;
         bus.output_enable_n        <= 1'b0;
      end else begin
         bus.clock_enable_n         <= usr_hold;
         bus.sleep_request          <= usr_sleep;
         bus.advance_or_load        <= usr_req_valid & usr_req_burst;
         bus.read_not_write         <= ~usr_req_write;
         bus.select_low_a_n         <= ~is_load;
         bus.select_high_or_low_b_n <= ~is_load;
         bus.select_high            <= is_load;
         // read lanes are don't-care; full-word users pass all ones
         bus.lane_write_enable_n    <= ~usr_req_lanes;
         bus.word_address           <= usr_req_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // shadow of what the pins carry, for data timing
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         act_r      <= 1'b0;
         wr_r       <= 1'b0;
         cmd_v_r    <= 1'b0;
         cmd_wr_r   <= 1'b0;
         cmd_data_r <= '0;
      end else begin
         cmd_v_r    <= take & (is_load | (usr_req_valid & act_r));
         cmd_wr_r   <= is_load ? usr_req_write : wr_r;
         cmd_data_r <= usr_req_wdata;
         if (take && is_load) begin
            act_r <= 1'b1;
            wr_r  <= usr_req_write;
         end else if (take && !usr_req_valid) begin
            act_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // data phase, counted on sram sampling edges only
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         p1_v_r        <= 1'b0;
         p1_wr_r       <= 1'b0;
         p1_data_r     <= '0;
         p2_v_r        <= 1'b0;
         p2_wr_r       <= 1'b0;
         p2_data_r     <= '0;
         p3_rd_r       <= 1'b0;
         bus.ctl_dq_out <= '0;
         bus.ctl_dq_oe  <= 1'b0;
         usr_rsp_valid <= 1'b0;
         usr_rsp_rdata <= '0;
      end else begin
         usr_rsp_valid <= 1'b0;
         if (dev_run) begin
            p1_v_r    <= cmd_v_r;
            p1_wr_r   <= cmd_wr_r;
            p1_data_r <= cmd_data_r;
            p2_v_r    <= p1_v_r;
            p2_wr_r   <= p1_wr_r;
            p2_data_r <= p1_data_r;
            p3_rd_r   <= p2_v_r & ~p2_wr_r;
            // write data go out two sampled edges after the command
            bus.ctl_dq_oe  <= p2_v_r & p2_wr_r;
            bus.ctl_dq_out <= p2_data_r;
            if (p3_rd_r) begin
               usr_rsp_valid <= 1'b1;
               usr_rsp_rdata <= bus.dq;
            end
         end
      end
   end
endmodule // pbsp_ctl_end
`default_nettype wire

// ### core/pbsp_if.sv
// pin bundle joining the sram end and the controller end
`timescale 1ns/1ps
`default_nettype none
interface pbsp_if #(
   parameter int DATA_W = pbsp_pkg::DATA_W,
   parameter int LANES  = pbsp_pkg::LANES,
   parameter int ADDR_W = pbsp_pkg::ADDR_W
) ();
   logic              clock_enable_n;
   logic              advance_or_load;
   logic              read_not_write;
   logic              select_low_a_n;
   logic              select_high_or_low_b_n;
   logic              select_high;
   logic [LANES-1:0]  lane_write_enable_n;
   logic [ADDR_W-1:0] word_address;
   logic              burst_order_select;
   logic              output_enable_n;
   logic              sleep_request;
   logic [DATA_W-1:0] dev_dq_out;
   logic              dev_dq_oe;
   logic [DATA_W-1:0] ctl_dq_out;
   logic              ctl_dq_oe;
   wire  [DATA_W-1:0] dq;

   // shared data wire resolved from the two enables; with no driver it
   // shows the inverse of the last read word, so a late sample shows up
   assign dq = dev_dq_oe ? dev_dq_out
                         : (ctl_dq_oe ? ctl_dq_out : ~dev_dq_out);

   modport dev (
      input  clock_enable_n, advance_or_load, read_not_write,
      input  select_low_a_n, select_high_or_low_b_n, select_high,
      input  lane_write_enable_n, word_address, burst_order_select,
      input  output_enable_n, sleep_request, dq,
      output dev_dq_out, dev_dq_oe
   );
   modport ctl (
      output clock_enable_n, advance_or_load, read_not_write,
      output select_low_a_n, select_high_or_low_b_n, select_high,
      output lane_write_enable_n, word_address, burst_order_select,
      output output_enable_n, sleep_request,
      output ctl_dq_out, ctl_dq_oe,
      input  dq
   );
endinterface // pbsp_if
`default_nettype wire

// ### core/pbsp_pkg.sv
// constants and helpers shared by both ends of the pipelined burst sram port
package pbsp_pkg;
   // 512K x 36 default; the 1M x 18 build uses 18, 2 and 20
   localparam int DATA_W    = 36;
   localparam int LANES     = 4;
   localparam int ADDR_W    = 19;
   localparam int DATA_LAT  = 2;
   localparam int BURST_LEN = 4;
   localparam int BCNT_W    = 2;
   localparam logic [BCNT_W-1:0] BCNT_RST  = 2'h0;
   localparam logic              ORDER_LIN = 1'b0;
   localparam logic              ORDER_ILV = 1'b1;

   // low address bits of burst beat cnt from start
   function automatic logic [BCNT_W-1:0] burst_low(
      input logic [BCNT_W-1:0] start,
      input logic [BCNT_W-1:0] cnt,
      input logic              ilv);
      logic [BCNT_W-1:0] res;
      res = ilv ? (start ^ cnt) : BCNT_W'(start + cnt);
      return res;
   endfunction
endpackage

// ### core/pbsp_sram_end.sv
// synchronous burst sram end: pipeline, burst counter, array, data drivers
`timescale 1ns/1ps
`default_nettype none
module pbsp_sram_end #(
   parameter int DATA_W = pbsp_pkg::DATA_W,
   parameter int LANES  = pbsp_pkg::LANES,
   parameter int ADDR_W = pbsp_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rst_b,
   pbsp_if.dev      bus
);
   import pbsp_pkg::*;

   localparam int LW    = DATA_W / LANES;
   localparam int DEPTH = 1 << ADDR_W;

   function automatic logic [DATA_W-1:0] lane_merge(
      input logic [DATA_W-1:0] old_w,
      input logic [DATA_W-1:0] new_w,
      input logic [LANES-1:0]  en);
      logic [DATA_W-1:0] res;
      res = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (en[i]) begin
            res[i*LW +: LW] = new_w[i*LW +: LW];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // command decode
   logic              run;
   logic              sel;
   logic              load;
   logic              desel;
   logic              issue_v;
   logic              issue_wr;
   logic [ADDR_W-1:0] issue_addr;
   logic [LANES-1:0]  issue_lanes;
   logic [ADDR_W-1:0] adv_addr;

   logic              bact_r;
   logic              bwr_r;
   logic [ADDR_W-1:0] bbase_r;
   logic [BCNT_W-1:0] bcnt_r;
   logic [BCNT_W-1:0] bcnt_nxt;

   // sleep gates the clock like a held clock enable, so nothing
   // sampled while asleep can become a command on wake-up
   assign run   = ~bus.clock_enable_n & ~bus.sleep_request;
   assign sel   = ~bus.select_low_a_n & ~bus.select_high_or_low_b_n
                  & bus.select_high;
   assign load  = ~bus.advance_or_load & sel;
   assign desel = ~bus.advance_or_load & ~sel;
   assign bcnt_nxt = BCNT_W'(bcnt_r + 1'b1);
   assign adv_addr = {bbase_r[ADDR_W-1:BCNT_W],
                      burst_low(bbase_r[BCNT_W-1:0], bcnt_nxt,
                                bus.burst_order_select)};

   always_comb begin
      issue_v     = load | (bus.advance_or_load & bact_r);
      issue_wr    = load ? ~bus.read_not_write : bwr_r;
      issue_addr  = load ? bus.word_address : adv_addr;
      issue_lanes = issue_wr ? ~bus.lane_write_enable_n : '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // burst counter
   // burst live flag: an advance with no live burst is a no-op
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bact_r <= 1'b0;
      end else if (run) begin
         if (load) begin
            bact_r <= 1'b1;
         end else if (desel) begin
            bact_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bwr_r   <= 1'b0;
         bbase_r <= '0;
      end else if (run && load) begin
         bwr_r   <= ~bus.read_not_write;
         bbase_r <= bus.word_address;
      end
   end

   // the count wraps after four beats and keeps going until a new load or a deselect
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         bcnt_r <= BCNT_RST;
      end else if (run) begin
         if (load) begin
            bcnt_r <= BCNT_RST;
         end else if (bact_r && bus.advance_or_load) begin
            bcnt_r <= bcnt_nxt;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // two-stage command pipeline plus write-data stage
   logic              s1_v_r;
   logic              s1_wr_r;
   logic [ADDR_W-1:0] s1_addr_r;
   logic [LANES-1:0]  s1_lanes_r;
   logic              s2_v_r;
   logic              s2_wr_r;
   logic [ADDR_W-1:0] s2_addr_r;
   logic [LANES-1:0]  s2_lanes_r;
   logic              s3_v_r;
   logic [ADDR_W-1:0] s3_addr_r;
   logic [LANES-1:0]  s3_lanes_r;

   // stage 1: command just taken
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_v_r     <= 1'b0;
         s1_wr_r    <= 1'b0;
         s1_addr_r  <= '0;
         s1_lanes_r <= '0;
      end else if (run) begin
         // a deselect inserts a bubble but leaves older stages moving
         s1_v_r     <= issue_v;
         s1_wr_r    <= issue_wr;
         s1_addr_r  <= issue_addr;
         s1_lanes_r <= issue_lanes;
      end
   end

   // stage 2: address reads the array for the data cycle
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s2_v_r     <= 1'b0;
         s2_wr_r    <= 1'b0;
         s2_addr_r  <= '0;
         s2_lanes_r <= '0;
      end else if (run) begin
         s2_v_r     <= s1_v_r;
         s2_wr_r    <= s1_wr_r;
         s2_addr_r  <= s1_addr_r;
         s2_lanes_r <= s1_lanes_r;
      end
   end

   // stage 3: a write waits here while its data stand on the wire
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s3_v_r     <= 1'b0;
         s3_addr_r  <= '0;
         s3_lanes_r <= '0;
      end else if (run) begin
         s3_v_r     <= s2_v_r & s2_wr_r;
         s3_addr_r  <= s2_addr_r;
         s3_lanes_r <= s2_lanes_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // array: no reset, contents survive sleep
   logic [DATA_W-1:0] mem [DEPTH];
   logic [DATA_W-1:0] rd_word;
   logic              byp;

   // a read right behind a write to the same word must see the new
   // bytes, since the array write lands on the same edge as the read
   assign byp     = s3_v_r & (s3_addr_r == s2_addr_r);
   assign rd_word = byp ? lane_merge(mem[s2_addr_r], bus.dq, s3_lanes_r)
                        : mem[s2_addr_r];

   always_ff @(posedge clk) begin
      if (run && s3_v_r) begin
         // the write data are sampled at this edge: input register
         mem[s3_addr_r] <= lane_merge(mem[s3_addr_r], bus.dq,
                                      s3_lanes_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data register and bus drive
   logic [DATA_W-1:0] dout_r;
   logic              drive_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         drive_r <= 1'b0;
      end else if (run) begin
         drive_r <= s2_v_r & ~s2_wr_r;
      end
   end

   // the word stays until the next read; only the drive flag moves
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dout_r <= '0;
      end else if (run && s2_v_r && !s2_wr_r) begin
         dout_r <= rd_word;
      end
   end

   // output enable must act without the clock, so this gate is the one
   // output not taken straight from a flip-flop
   assign bus.dev_dq_out = dout_r;
   assign bus.dev_dq_oe  = drive_r & ~bus.output_enable_n;
endmodule // pbsp_sram_end
`default_nettype wire

// ### tb/pbsp_properties.sv
// pin-level checks between the sram end and the controller end
`timescale 1ns/1ps
`default_nettype none
module pbsp_properties #(
   parameter int DATA_W = 36
) (
   input wire logic              clk,
   input wire logic              rst_b,
   input wire logic              clock_enable_n,
   input wire logic              advance_or_load,
   input wire logic              read_not_write,
   input wire logic              select_low_a_n,
   input wire logic              select_high_or_low_b_n,
   input wire logic              select_high,
   input wire logic              burst_order_select,
   input wire logic              sleep_request,
   input wire logic [DATA_W-1:0] dev_dq_out,
   input wire logic              dev_dq_oe,
   input wire logic              ctl_dq_oe
);
   logic run, sel, ld_rd, ld_wr, desel, adv;
   // stalled edges never count toward the two-cycle data slot
   assign run   = !clock_enable_n && !sleep_request;
   assign sel   = !select_low_a_n && !select_high_or_low_b_n && select_high;
   assign ld_rd = run && !advance_or_load && sel && read_not_write;
   assign ld_wr = run && !advance_or_load && sel && !read_not_write;
   assign desel = run && !advance_or_load && !sel;
   assign adv   = run && advance_or_load;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////////////////////////////////////////
   read_lat_a: assert property (ld_rd ##1 run [*2] |=> dev_dq_oe)
      else $error("read data not driven two run edges after load");
   write_lat_a: assert property (ld_wr ##1 run [*2] |=>
      ctl_dq_oe && !dev_dq_oe)
      else $error("write slot not owned by controller");
   desel_float_a: assert property (desel ##1 run [*2] |=> !dev_dq_oe)
      else $error("sram drives after deselect");
   burst_beat_a: assert property (ld_rd ##1 adv ##1 run [*2] |=>
      dev_dq_oe)
      else $error("burst beat read not driven");
   hold_freeze_a: assert property (clock_enable_n |=>
      $stable(dev_dq_oe) && $stable(dev_dq_out))
      else $error("sram outputs moved on a held edge");
   sleep_keep_a: assert property (sleep_request |=>
      $stable(dev_dq_oe) && $stable(dev_dq_out))
      else $error("sram outputs moved while asleep");
   no_clash_a: assert property (!(dev_dq_oe && ctl_dq_oe))
      else $error("both ends drive the data wire");
   order_fixed_a: assert property ($stable(burst_order_select))
      else $error("burst order changed in operation");
endmodule // pbsp_properties
`default_nettype wire

// ### tb/tb.sv
// self-checking bench: a linear pair and an interleaved pair, same stimulus
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pbsp_pkg::*;
   localparam int AW = 6;
   localparam int LW = DATA_W / LANES;
   logic              clk, rst_b, v, bu, wr, hold, slp, act, bwr;
   logic [AW-1:0]     addr, st;
   logic [LANES-1:0]  ln;
   logic [DATA_W-1:0] wd;
   logic [1:0]        rv, beat;
   logic [DATA_W-1:0] rd [2];
   logic [DATA_W-1:0] mem [2][2**AW];
   logic [DATA_W-1:0] expq [2][$];
   logic [31:0]       seed, r;
   int                n_errors, compares;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [DATA_W-1:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return {seed[3:0], seed};
   endfunction
   function automatic logic [AW-1:0] baddr(input logic [AW-1:0] s,
      input logic [1:0] n, input logic o);
      return {s[AW-1:2], o ? s[1:0] ^ n : s[1:0] + n};
   endfunction
   function automatic logic [DATA_W-1:0] mrg(input logic [DATA_W-1:0] o, d,
      input logic [LANES-1:0] l);
      for (int i = 0; i < LANES; i++)
         if (l[i]) o[i*LW +: LW] = d[i*LW +: LW];
      return o;
   endfunction
   task automatic chk(input string nm, input logic [DATA_W-1:0] e, g);
      compares++;
      if (e !== g) begin
         n_errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   for (genvar g = 0; g < 2; g++) begin : p
      pbsp_if #(.ADDR_W(AW)) b ();
      pbsp_sram_end #(.ADDR_W(AW)) i_pbsp_sram_end (.clk(clk), .rst_b(rst_b),
         .bus(b));
      pbsp_ctl_end #(.ADDR_W(AW), .BURST_ORDER(g == 1)) i_pbsp_ctl_end (
         .clk(clk), .rst_b(rst_b), .bus(b), .usr_req_valid(v),
         .usr_req_burst(bu), .usr_req_write(wr), .usr_req_addr(addr),
         .usr_req_lanes(ln), .usr_req_wdata(wd), .usr_hold(hold),
         .usr_sleep(slp), .usr_rsp_valid(rv[g]), .usr_rsp_rdata(rd[g]));
   end
   pbsp_properties #(.DATA_W(DATA_W)) i_pbsp_properties (.clk(clk),
      .rst_b(rst_b), .clock_enable_n(p[0].b.clock_enable_n),
      .advance_or_load(p[0].b.advance_or_load),
      .read_not_write(p[0].b.read_not_write),
      .select_low_a_n(p[0].b.select_low_a_n),
      .select_high_or_low_b_n(p[0].b.select_high_or_low_b_n),
      .select_high(p[0].b.select_high),
      .burst_order_select(p[0].b.burst_order_select),
      .sleep_request(p[0].b.sleep_request), .dev_dq_out(p[0].b.dev_dq_out),
      .dev_dq_oe(p[0].b.dev_dq_oe), .ctl_dq_oe(p[0].b.ctl_dq_oe));
   // responses come back in request order, so a queue per pair suffices
   always @(posedge clk) begin
      for (int g = 0; g < 2; g++)
         if (rv[g] === 1'b1)
            chk("rdata", expq[g].pop_front(), rd[g]);
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic op(input logic iv, ib, iw, ih, is, input logic [AW-1:0] ia,
      input logic [LANES-1:0] il, input logic [DATA_W-1:0] id);
      logic [AW-1:0] a, pa;
      logic          pv, pb, pw, ph, ps;
      @(posedge clk);
      {pv, pb, pw, ph, ps, pa} = {v, bu, wr, hold, slp, addr};
      {v, bu, wr, hold, slp} <= {iv, ib, iw, ih, is};
      addr <= ia;
      ln   <= il;
      wd   <= id;
      #1;
      if (!ps)
         chk("cen_pin", DATA_W'(ph), DATA_W'(p[0].b.clock_enable_n));
      if (!ph && !ps && pv && !pb) begin
         chk("sel_pins", DATA_W'(4'b0001), DATA_W'({p[0].b.advance_or_load,
            p[0].b.select_low_a_n, p[0].b.select_high_or_low_b_n,
            p[0].b.select_high}));
         chk("rw_pin", DATA_W'(!pw), DATA_W'(p[0].b.read_not_write));
         chk("addr_pin", DATA_W'(pa), DATA_W'(p[0].b.word_address));
      end
      if (!ph && !ps && pv && pb && act)
         chk("adv_pin", DATA_W'(1), DATA_W'(p[0].b.advance_or_load));
      if (ih || is) return;
      if (!iv) act = 1'b0;
      else if (!ib) {act, st, beat, bwr} = {1'b1, ia, 2'b00, iw};
      else if (act) beat = beat + 2'b01;
      if (iv && (!ib || act))
         for (int g = 0; g < 2; g++) begin
            a = ib ? baddr(st, beat, g[0]) : ia;
            if (bwr) mem[g][a] = mrg(mem[g][a], id, il);
            else expq[g].push_back(mem[g][a]);
         end
   endtask
   initial begin
      #100_000;
      n_errors++;
      end_sim();
   end
   initial begin
      seed = 32'h0fee;
      {v, bu, wr, hold, slp, act, bwr} = '0;
      {addr, st, ln, wd, beat} = '0;
      n_errors = 0;
      compares = 0;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 2**AW; i++)
         op(1, 0, 1, 0, 0, AW'(i), '1, rnd());
      op(1, 0, 1, 0, 0, 6'd5, 4'b0101, rnd());
      op(1, 0, 0, 0, 0, 6'd5, 4'b0000, '0);
      op(1, 0, 0, 0, 0, 6'd9, 4'b1111, '0);
      repeat (5) op(1, 1, 0, 0, 0, '0, '1, '0);
      op(1, 0, 1, 0, 0, 6'd14, 4'b1001, rnd());
      op(1, 1, 1, 1, 0, '0, 4'b1111, rnd());
      op(1, 1, 1, 0, 1, '0, 4'b1111, rnd());
      repeat (3) op(1, 1, 1, 0, 0, '0, 4'b0110, rnd());
      op(0, 0, 0, 0, 0, '0, '0, '0);
      op(1, 1, 0, 0, 0, '0, '0, '0);
      for (int i = 0; i < 1500; i++) begin
         r = 32'(rnd());
         op(r[0] | r[1], r[2], r[3], r[7:4] == 0, r[11:8] == 0, r[AW+11:12],
            r[19:16], rnd());
      end
      repeat (12) op(0, 0, 0, 0, 0, '0, '0, '0);
      chk("pending", DATA_W'(0),
          DATA_W'(expq[0].size() + expq[1].size()));
      chk("order0", DATA_W'(0), DATA_W'(p[0].b.burst_order_select));
      chk("order1", DATA_W'(1), DATA_W'(p[1].b.burst_order_select));
      end_sim();
   end
endmodule // tb
`default_nettype wire
